// ### design/aps_defs.svh
// Constants for the audio port power and clock supervisor.
// Assumes inclusion by bare name; definitions only.
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH
`define APS_ADDR_CTRL 8'h00
`define APS_ADDR_STAT 8'h04
`define APS_ADDR_ADCD 8'h08
`define APS_ADDR_DACD 8'h0C
`define APS_CTRL_ADC_EN 0
`define APS_CTRL_DAC_EN 1
`define APS_CTRL_REGMODE 2
`define APS_CTRL_RATIO_LO 4
`define APS_CTRL_RATIO_HI 5
`define APS_CTRL_RESET 32'h0000_0034
`define APS_CTRL_MASK 32'h0000_0037
`define APS_RELEASE_FRAMES 64
`define APS_VALID_FRAMES 528
`define APS_BITS_PER_FRAME 64
`define APS_STOP_TIMEOUT_NS 10000
`define APS_CLK_NS 8
`define APS_STOP_CYCLES (`APS_STOP_TIMEOUT_NS / `APS_CLK_NS)
`endif

// ### design/aps_pkg.sv
// Types used by the supervisor; its FIFO uses none of them.
// Assumes aps_defs.svh is compiled alongside.
package aps_pkg;
  typedef enum logic [1:0] {APS_OFF, APS_WAIT_CLK, APS_RELEASE, APS_RUN} aps_state_t;
  typedef struct packed {
    logic [2:0] stopped;
    logic [2:0] seen;
  } aps_clk_t;
endpackage

// ### design/aps_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ns
module aps_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (push) mem[wp_r[AW-1:0]] <= in_data;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// ### design/aps_supervisor.sv
// Power and clock supervisor for an ADC port and a DAC port.
// Assumes port clocks are sampled as plain inputs on mclk (125 MHz) and APB master.
// Contract
// - ADC power-down rising: count 64 frame periods, then release ADC power-down.
// - Valid ADC serial output starts 528 frame periods after release.
// - Register mode: converter runs only when pin high and enable bit one.
// - Pin mode: converter runs whenever its power-down pin is high.
// - ADC master mode: stopped ADC master clock powers the ADC down.
// - Slave mode: any one of the three port clocks stopped powers that converter down.
// - Powered down: ADC data reads zero, DAC output pulled low.
// - Supplying required clocks again resumes operation.
// - After pin rises, converter stays down until all its clocks are seen; ADC master mode waits for the master clock only.
// - ADC and DAC ports run independently, each with its own clocks.
// - Master select steers only the ADC port; DAC port always slave.
// - Master mode drives ADC frame and bit clocks; slave mode inputs.
// - Master bit clock runs at 64 times sample rate, 50 percent duty.
// - Ratio field picks 256/384/512/768 fs master clock, 768 default.
`timescale 1ns/1ns
`include "aps_defs.svh"
module aps_supervisor #(
  parameter int STOP_CYCLES = `APS_STOP_CYCLES,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_powerdown_n,
  input wire logic dac_powerdown_n,
  input wire logic port_master_select,
  input wire logic adc_master_clock,
  input wire logic dac_master_clock,
  input wire logic adc_frame_clock_i,
  output logic adc_frame_clock_o,
  output logic adc_frame_clock_oe,
  input wire logic adc_bit_clock_i,
  output logic adc_bit_clock_o,
  output logic adc_bit_clock_oe,
  input wire logic dac_frame_clock,
  input wire logic dac_bit_clock,
  input wire logic [31:0] adc_sample,
  input wire logic adc_sample_valid,
  output logic adc_sample_ready,
  output logic [31:0] adc_serial_output,
  output logic adc_data_valid,
  output logic adc_active,
  output logic dac_active,
  output logic dac_output_pulldown
);
  initial begin
    if (STOP_CYCLES < 2) $error("STOP_CYCLES too small");
  end
  logic [31:0] ctrl_r;
  wire reg_mode = ctrl_r[`APS_CTRL_REGMODE];
  wire [1:0] ratio = ctrl_r[`APS_CTRL_RATIO_HI:`APS_CTRL_RATIO_LO];

  // Clock activity per port: edge detect on sampled clocks, timeout on silence
  wire [5:0] clk_in = {adc_master_clock, adc_frame_clock_i, adc_bit_clock_i,
                       dac_master_clock, dac_frame_clock, dac_bit_clock};
  logic [5:0] clk_d_r;
  logic [5:0] clk_live;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_det
      logic [31:0] idle_r;
      always_ff @(posedge mclk) begin
        if (reset) idle_r <= STOP_CYCLES;
        else if (clk_in[gi] != clk_d_r[gi]) idle_r <= '0;
        else if (idle_r < STOP_CYCLES) idle_r <= idle_r + 1;
      end
      assign clk_live[gi] = idle_r < STOP_CYCLES;
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (reset) clk_d_r <= '0;
    else clk_d_r <= clk_in;
  end
  aps_pkg::aps_clk_t adc_clk, dac_clk;
  assign adc_clk.seen = clk_live[5:3];
  assign adc_clk.stopped = ~clk_live[5:3];
  assign dac_clk.seen = clk_live[2:0];
  assign dac_clk.stopped = ~clk_live[2:0];

  // Master mode needs only the master clock; its frame/bit clocks are ours
  wire adc_clk_ok = port_master_select ? adc_clk.seen[2] : &adc_clk.seen;
  wire dac_clk_ok = &dac_clk.seen;
  wire adc_en = adc_powerdown_n && (!reg_mode || ctrl_r[`APS_CTRL_ADC_EN]);
  wire dac_en = dac_powerdown_n && (!reg_mode || ctrl_r[`APS_CTRL_DAC_EN]);

  // Master clock divider: master clock edges per half bit clock
  logic [3:0] half_bit;
  assign half_bit = (ratio == 2'b00) ? 4'h2 : (ratio == 2'b01) ? 4'h3 :
                    (ratio == 2'b10) ? 4'h4 : 4'h6;
  wire mclk_rise = adc_master_clock && !clk_d_r[5];
  logic [3:0] div_r;
  logic [5:0] bit_cnt_r;
  logic bclk_r, fclk_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_r <= '0;
      bclk_r <= 1'b0;
      bit_cnt_r <= '0;
      fclk_r <= 1'b0;
    end else if (mclk_rise) begin
      if (div_r == half_bit - 4'h1) begin
        div_r <= '0;
        bclk_r <= !bclk_r;
        if (bclk_r) begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
          if (bit_cnt_r == 6'(`APS_BITS_PER_FRAME / 2 - 1) || bit_cnt_r == 6'(`APS_BITS_PER_FRAME - 1))
            fclk_r <= !fclk_r;
        end
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end
  assign adc_bit_clock_o = bclk_r;
  assign adc_frame_clock_o = fclk_r;
  assign adc_bit_clock_oe = port_master_select;
  assign adc_frame_clock_oe = port_master_select;

  // Frame tick from whichever frame clock the ADC port uses
  wire fclk_src = port_master_select ? fclk_r : adc_frame_clock_i;
  logic fclk_d_r;
  always_ff @(posedge mclk) begin
    if (reset) fclk_d_r <= 1'b0;
    else fclk_d_r <= fclk_src;
  end
  wire frame_tick = fclk_src && !fclk_d_r;

  // ADC sequencer
  aps_pkg::aps_state_t st_r, st_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      aps_pkg::APS_OFF: begin
        if (adc_en) st_nxt = aps_pkg::APS_WAIT_CLK;
      end
      aps_pkg::APS_WAIT_CLK: begin
        cnt_nxt = '0;
        if (adc_clk_ok) st_nxt = aps_pkg::APS_RELEASE;
      end
      aps_pkg::APS_RELEASE: begin
        if (frame_tick) cnt_nxt = cnt_r + 10'h001;
        if (frame_tick && cnt_r == 10'(`APS_RELEASE_FRAMES - 1)) begin
          st_nxt = aps_pkg::APS_RUN;
          cnt_nxt = '0;
        end
      end
      aps_pkg::APS_RUN: begin
        if (frame_tick && cnt_r != 10'(`APS_VALID_FRAMES)) cnt_nxt = cnt_r + 10'h001;
      end
      default: st_nxt = aps_pkg::APS_OFF;
    endcase
    if (!adc_en) st_nxt = aps_pkg::APS_OFF;
    else if (!adc_clk_ok && st_r != aps_pkg::APS_OFF) st_nxt = aps_pkg::APS_WAIT_CLK;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= aps_pkg::APS_OFF;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign adc_active = st_r == aps_pkg::APS_RUN;
  wire adc_valid_now = adc_active && cnt_r == 10'(`APS_VALID_FRAMES);

  // Sample path: FIFO drains one word per frame once output is valid
  logic [31:0] fifo_data;
  logic fifo_valid;
  wire fifo_pop = adc_valid_now && frame_tick;
  aps_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_data(adc_sample),
    .in_valid(adc_sample_valid),
    .in_ready(adc_sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // Clear on the next-state view so the word is already zero when valid drops
  wire adc_valid_nxt = st_nxt == aps_pkg::APS_RUN && cnt_nxt == 10'(`APS_VALID_FRAMES);
  logic [31:0] sdo_r;
  always_ff @(posedge mclk) begin
    if (reset) sdo_r <= '0;
    else if (!adc_valid_nxt) sdo_r <= '0;
    else if (fifo_pop && fifo_valid) sdo_r <= fifo_data;
  end
  assign adc_serial_output = sdo_r;
  assign adc_data_valid = adc_valid_now;

  logic dac_run_r;
  always_ff @(posedge mclk) begin
    if (reset) dac_run_r <= 1'b0;
    else dac_run_r <= dac_en && dac_clk_ok;
  end
  assign dac_active = dac_run_r;
  assign dac_output_pulldown = !dac_run_r;

  // APB slave, zero wait states
  wire hit_ctrl = paddr == `APS_ADDR_CTRL;
  wire hit_stat = paddr == `APS_ADDR_STAT;
  wire hit_adcd = paddr == `APS_ADDR_ADCD;
  wire hit_dacd = paddr == `APS_ADDR_DACD;
  wire hit_any = hit_ctrl || hit_stat || hit_adcd || hit_dacd;
  wire wr_ctrl = psel && penable && pwrite && hit_ctrl;
  wire [31:0] stat_word = {20'h0, 2'(st_r), 1'b0, adc_data_valid, dac_active, adc_active,
                           adc_clk.seen, dac_clk.seen};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  always_ff @(posedge mclk) begin
    if (reset) ctrl_r <= `APS_CTRL_RESET;
    else if (wr_ctrl) ctrl_r <= pwdata & `APS_CTRL_MASK;
  end
  assign prdata = hit_ctrl ? ctrl_r : hit_stat ? stat_word :
                  hit_adcd ? sdo_r : hit_dacd ? {31'h0, dac_active} : 32'h0000_0000;
endmodule

// ### bench/aps_checker.sv
// Port-level power and clock-direction checks for the supervisor.
// Assumes the bind below; one clock domain, mclk, with sync reset.
`timescale 1ns/1ns
module aps_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic adc_powerdown_n,
  input wire logic dac_powerdown_n,
  input wire logic port_master_select,
  input wire logic adc_frame_clock_oe,
  input wire logic adc_bit_clock_oe,
  input wire logic [31:0] adc_serial_output,
  input wire logic adc_data_valid,
  input wire logic adc_active,
  input wire logic dac_active,
  input wire logic dac_output_pulldown
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_bit_oe_sel: assert property (adc_bit_clock_oe == port_master_select) else $error("bit oe");
  a_frame_oe_sel: assert property (adc_frame_clock_oe == port_master_select) else $error("frame oe");
  a_dac_pull_low: assert property (dac_output_pulldown != dac_active) else $error("pulldown");
  a_adc_zero_out: assert property (!adc_data_valid |-> adc_serial_output == 32'h0) else $error("data");
  a_adc_pin_off: assert property (!adc_powerdown_n |-> ##[1:2] !adc_active) else $error("adc on");
  a_dac_pin_off: assert property (!dac_powerdown_n |-> ##[1:2] !dac_active) else $error("dac on");
  a_valid_when_up: assert property (adc_data_valid |-> adc_active) else $error("valid");
  a_up_needs_pin: assert property ($rose(dac_active) |-> $past(dac_powerdown_n)) else $error("dac up");
  cover property ($rose(adc_data_valid));
  cover property ($fell(dac_active));
  cover property ($rose(adc_active));
endmodule
bind aps_supervisor aps_checker u_chk (.mclk, .reset, .adc_powerdown_n, .dac_powerdown_n, .port_master_select,
  .adc_frame_clock_oe, .adc_bit_clock_oe, .adc_serial_output, .adc_data_valid, .adc_active, .dac_active,
  .dac_output_pulldown);

// ### bench/aps_host_model.sv
// Audio host driving one port's master, frame and bit clocks.
// Assumes mclk as time base; clocks stand still while run is low.
`timescale 1ns/1ns
module aps_host_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  output logic mck,
  output logic fck,
  output logic bck
);
  logic [6:0] cnt_r;
  always_ff @(posedge mclk) begin
    if (reset) cnt_r <= 7'h00;
    else if (run) cnt_r <= cnt_r + 7'h01;
  end
  assign mck = cnt_r[1]; // One counter keeps all three locked
  assign bck = cnt_r[0];
  assign fck = cnt_r[6]; // Moves only as bck falls
endmodule

// ### bench/testbench.sv
// Self-checking bench for the power and clock supervisor.
// Assumes aps_supervisor, aps_host_model and the checker bind are compiled.
`timescale 1ns/1ns
module testbench;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err_r, adc_sample_valid = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, adc_sample = 32'h0, prdata, q, adc_serial_output;
  logic adc_powerdown_n = 0, dac_powerdown_n = 0, port_master_select = 0, a_run = 0, d_run = 0, f_prev = 0;
  logic pready, pslverr, adc_sample_ready, a_m, a_f, a_b, d_m, d_f, d_b, fo, foe, bo, boe;
  logic adc_data_valid, adc_active, dac_active, dac_output_pulldown;
  int mismatches = 0, checks_done = 0, frames = 0, n, hi, lo, f0;
  int div[4] = '{2, 3, 4, 6};
  wire logic [3:0] mon = {bo, adc_data_valid, dac_active, adc_active};
  wire logic fsrc = foe ? fo : a_f;
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    f_prev <= fsrc;
    if (fsrc & !f_prev) frames <= frames + 1;
  end
  aps_host_model u_ah (.mclk, .reset, .run(a_run), .mck(a_m), .fck(a_f), .bck(a_b));
  aps_host_model u_dh (.mclk, .reset, .run(d_run), .mck(d_m), .fck(d_f), .bck(d_b));
  aps_supervisor #(.STOP_CYCLES(100), .FIFO_DEPTH(32)) u_dut (.*, .adc_master_clock(a_m), .dac_master_clock(d_m),
    .adc_frame_clock_i(fsrc), .adc_frame_clock_o(fo), .adc_frame_clock_oe(foe),
    .adc_bit_clock_i(boe ? bo : a_b), .adc_bit_clock_o(bo), .adc_bit_clock_oe(boe),
    .dac_frame_clock(d_f), .dac_bit_clock(d_b));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    mismatches++;
    $display("[ERR] %0t wait timed out", $time);
    end_of_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    k = 0;
    do @(posedge mclk) k++; while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    q = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_sig(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (mon[k] !== v && c < lim) begin
      @(posedge mclk);
      c++;
    end
    if (c >= lim) hang();
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    apb(0, 8'h00, 0);
    check(q, 32'h34);
    apb(0, 8'h10, 0);
    check({q[30:0], err_r}, 32'h1);
    apb(1, 8'h00, 32'h36);
    d_run <= 1'b1;
    dac_powerdown_n <= 1'b1;
    wait_sig(1, 1, 400, n);
    check(dac_output_pulldown, 0);
    apb(1, 8'h00, 32'h34);
    wait_sig(1, 0, 10, n);
    check(dac_output_pulldown, 1);
    apb(1, 8'h00, 32'h30);
    wait_sig(1, 1, 10, n);
    check(dac_active, 1);
    d_run <= 1'b0;
    wait_sig(1, 0, 200, n);
    check(n >= 90, 1);
    d_run <= 1'b1;
    wait_sig(1, 1, 400, n);
    check(dac_active, 1);
    // Fill the FIFO while the ADC is still down so nothing drains
    apb(1, 8'h00, 32'h37);
    n = 0;
    adc_sample <= 32'h1;
    adc_sample_valid <= 1'b1;
    repeat (40) begin
      @(posedge mclk);
      if (adc_sample_ready === 1'b1) begin
        n++;
        adc_sample <= n + 1;
      end
    end
    adc_sample_valid <= 1'b0;
    check(n, 32);
    a_run <= 1'b1;
    adc_powerdown_n <= 1'b1;
    f0 = frames;
    wait_sig(0, 1, 9500, n);
    check((frames - f0) inside {[64:66]}, 1);
    f0 = frames;
    wait_sig(2, 1, 70000, n);
    check((frames - f0) inside {[528:529]}, 1);
    n = 0;
    while (adc_serial_output === 32'h0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check(adc_serial_output, 1);
    port_master_select <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      apb(1, 8'h00, 32'h07 | (r << 4));
      wait_sig(3, 0, 200, n);
      wait_sig(3, 1, 200, n);
      wait_sig(3, 0, 200, hi);
      wait_sig(3, 1, 200, lo);
      check(hi, 4 * div[r]);
      check(lo, hi);
    end
    // Last ratio is 768: a frame is 64 bits of 48 cycles, so two frames span 6144 cycles
    f0 = frames;
    repeat (6144) @(posedge mclk);
    check(frames - f0, 2);
    end_of_test();
  end
endmodule
